// >>> common/pcg_regs.svh
// register offsets, field positions and reset values of the clock gates
// assumes a 32-bit avalon-mm slave with byte addresses, one word per index
//
// Behaviour
// - enable bit zero stops the peripheral clock
// - enable bit one delivers the peripheral clock
// - reset clears all four gating registers
// - timer register: bits 5,4,1,0 gate timers
// - serial register: bit 4 i2c, 1,0 uarts
// - third register gates rtc and sync serial
// - external irq register: bits 5..0 gate inputs
`ifndef PCG_REGS_SVH
`define PCG_REGS_SVH

// register indices; byte address is four times the index
`define PCG_IDX_TIMER 12'hf74
`define PCG_IDX_SERIAL 12'hf75
`define PCG_IDX_RTC_SIO 12'hf76
`define PCG_IDX_EXT_IRQ 12'hf77
`define PCG_IDX_STATUS 12'hf78
`define PCG_BYTE_ADDR(idx) {idx, 2'b00}

`define PCG_RESET_VAL 8'h00

// field positions inside each gating register
`define PCG_TIMER_PAIR_B_BIT 5
`define PCG_TIMER_PAIR_A_BIT 4
`define PCG_TIMER_A_UNIT1_BIT 1
`define PCG_TIMER_A_UNIT0_BIT 0
`define PCG_I2C_PORT_BIT 4
`define PCG_ASYNC_PORT1_BIT 1
`define PCG_ASYNC_PORT0_BIT 0
`define PCG_REALTIME_CLOCK_BIT 1
`define PCG_SYNC_SERIAL_BIT 0

// gated clock vector layout
`define PCG_NUM_GATES 15
`define PCG_G_TIMER 0
`define PCG_G_SERIAL 4
`define PCG_G_RTC 7
`define PCG_G_SIO 8
`define PCG_G_EXT_IRQ 9

`endif

// >>> common/pcg_pkg.sv
// types shared by the clock gating top and its gate bank
// assumes pcg_regs.svh for the widths
`include "pcg_regs.svh"

package pcg_pkg;
   typedef logic [7:0] pcg_byte_t;
   typedef logic [`PCG_NUM_GATES-1:0] pcg_gate_vec_t;
   typedef enum logic [1:0] {
      PCG_ST_IDLE = 2'b01,
      PCG_ST_DONE = 2'b10
   } pcg_bus_state_e;
endpackage : pcg_pkg

// >>> common/pcg_gate_if.sv
// enables to the gate bank, gated clocks and activity back
// assumes both ends run on sys_clk
`timescale 1ns/100ps
interface pcg_gate_if;
   pcg_pkg::pcg_gate_vec_t enable;
   pcg_pkg::pcg_gate_vec_t gclk;
   pcg_pkg::pcg_gate_vec_t active;
   modport ctrl (output enable, input gclk, input active);
   modport bank (input enable, output gclk, output active);
endinterface : pcg_gate_if

// >>> rtl/pcg_gate_bank.sv
// one glitch-free gated basic clock per enable bit
// assumes sys_clk free running; each basic clock is sys_clk divided by two
`timescale 1ns/100ps
`include "pcg_regs.svh"
module pcg_gate_bank (
   input wire logic sys_clk,
   input wire logic rstn,
   pcg_gate_if.bank gates
);
   genvar g;
   generate
      for (g = 0; g < `PCG_NUM_GATES; g = g + 1) begin : gen_gate
         logic clk_q;
         logic clk_d;
         logic act_q;
         // a high phase always completes before the clock parks low,
         // and a restart only begins from low, so no pulse is cut short
         assign clk_d = clk_q ? 1'b0 : gates.enable[g];
         always_ff @(posedge sys_clk or negedge rstn) begin
            if (!rstn) begin
               clk_q <= 1'b0;
               act_q <= 1'b0;
            end else begin
               clk_q <= clk_d;
               act_q <= clk_d | clk_q;
            end
         end
         assign gates.gclk[g] = clk_q;
         assign gates.active[g] = act_q;
      end
   endgenerate
endmodule : pcg_gate_bank

// >>> rtl/pcg_top.sv
// peripheral clock gating: four gating registers on avalon-mm,
// fifteen gated basic clocks out
// assumes a single avalon master on sys_clk; peripherals take the
// gated clocks as their basic clock
//
// The Avalon-MM slave port is this design's own decision.
`timescale 1ns/100ps
`include "pcg_regs.svh"
module pcg_top (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic [13:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic [1:0] avs_response,
   output logic [3:0] timer_clk,
   output logic [2:0] serial_clk,
   output logic rtc_clk,
   output logic sio_clk,
   output logic [5:0] ext_irq_clk
);
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_DECODEERROR = 2'b11;
   localparam logic [13:0] ADDR_TIMER = `PCG_BYTE_ADDR(`PCG_IDX_TIMER);
   localparam logic [13:0] ADDR_SERIAL = `PCG_BYTE_ADDR(`PCG_IDX_SERIAL);
   localparam logic [13:0] ADDR_RTC_SIO = `PCG_BYTE_ADDR(`PCG_IDX_RTC_SIO);
   localparam logic [13:0] ADDR_EXT_IRQ = `PCG_BYTE_ADDR(`PCG_IDX_EXT_IRQ);
   localparam logic [13:0] ADDR_STATUS = `PCG_BYTE_ADDR(`PCG_IDX_STATUS);

   pcg_pkg::pcg_byte_t timer_clock_gate_q;
   pcg_pkg::pcg_byte_t serial_clock_gate_q;
   pcg_pkg::pcg_byte_t rtc_sio_clock_gate_q;
   pcg_pkg::pcg_byte_t ext_irq_clock_gate_q;
   pcg_pkg::pcg_bus_state_e state_q;
   pcg_pkg::pcg_bus_state_e state_d;
   logic waitrequest_q;
   logic waitrequest_d;
   logic [31:0] readdata_q;
   logic [31:0] readdata_d;
   logic [1:0] response_q;
   logic [1:0] response_d;
   pcg_pkg::pcg_gate_vec_t gclk_q;

   pcg_gate_if gates ();

   // ---------------- address decode ----------------
   wire req = avs_read | avs_write;
   wire sel_timer = (avs_address == ADDR_TIMER);
   wire sel_serial = (avs_address == ADDR_SERIAL);
   wire sel_rtc_sio = (avs_address == ADDR_RTC_SIO);
   wire sel_ext_irq = (avs_address == ADDR_EXT_IRQ);
   wire sel_status = (avs_address == ADDR_STATUS);
   // reserved and other addresses answer decodeerror, read as zero
   wire mapped = sel_timer | sel_serial | sel_rtc_sio | sel_ext_irq
      | sel_status;
   // a write lands only at the edge where waitrequest is seen low
   wire accept = req & ~waitrequest_q;
   wire wr_lane0 = accept & avs_write & avs_byteenable[0];
   wire wr_timer = wr_lane0 & sel_timer;
   wire wr_serial = wr_lane0 & sel_serial;
   wire wr_rtc_sio = wr_lane0 & sel_rtc_sio;
   wire wr_ext_irq = wr_lane0 & sel_ext_irq;
   wire [7:0] wbyte = avs_writedata[7:0];

   // ---------------- read mux ----------------
   wire [31:0] rd_word =
      sel_timer ? {24'h000000, timer_clock_gate_q} :
      sel_serial ? {24'h000000, serial_clock_gate_q} :
      sel_rtc_sio ? {24'h000000, rtc_sio_clock_gate_q} :
      sel_ext_irq ? {24'h000000, ext_irq_clock_gate_q} :
      sel_status ? {17'h00000, gates.active} :
      32'h00000000;

   // ---------------- bus handshake ----------------
   // one wait cycle: data are captured while waitrequest is high, so
   // they already stand at the accepting edge
   always_comb begin
      state_d = state_q;
      waitrequest_d = 1'b1;
      readdata_d = readdata_q;
      response_d = response_q;
      case (state_q)
         pcg_pkg::PCG_ST_IDLE: begin
            if (req) begin
               state_d = pcg_pkg::PCG_ST_DONE;
               waitrequest_d = 1'b0;
               readdata_d = avs_read ? rd_word : 32'h00000000;
               response_d = mapped ? RESP_OKAY : RESP_DECODEERROR;
            end
         end
         pcg_pkg::PCG_ST_DONE: begin
            state_d = pcg_pkg::PCG_ST_IDLE;
         end
         default: begin
            state_d = pcg_pkg::PCG_ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         state_q <= pcg_pkg::PCG_ST_IDLE;
         waitrequest_q <= 1'b1;
         readdata_q <= 32'h00000000;
         response_q <= 2'b00;
      end else begin
         state_q <= state_d;
         waitrequest_q <= waitrequest_d;
         readdata_q <= readdata_d;
         response_q <= response_d;
      end
   end

   // ---------------- gating registers ----------------
   // every bit is read/write, including those with no gate behind them;
   // clearing a bit of a busy peripheral is software's hazard, not ours
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         timer_clock_gate_q <= `PCG_RESET_VAL;
         serial_clock_gate_q <= `PCG_RESET_VAL;
         rtc_sio_clock_gate_q <= `PCG_RESET_VAL;
         ext_irq_clock_gate_q <= `PCG_RESET_VAL;
      end else begin
         if (wr_timer) begin
            timer_clock_gate_q <= wbyte;
         end
         if (wr_serial) begin
            serial_clock_gate_q <= wbyte;
         end
         if (wr_rtc_sio) begin
            rtc_sio_clock_gate_q <= wbyte;
         end
         if (wr_ext_irq) begin
            ext_irq_clock_gate_q <= wbyte;
         end
      end
   end

   // ---------------- enable mapping ----------------
   wire timer_pair_b_gate = timer_clock_gate_q[`PCG_TIMER_PAIR_B_BIT];
   wire timer_pair_a_gate = timer_clock_gate_q[`PCG_TIMER_PAIR_A_BIT];
   wire timer_a_unit1_gate = timer_clock_gate_q[`PCG_TIMER_A_UNIT1_BIT];
   wire timer_a_unit0_gate = timer_clock_gate_q[`PCG_TIMER_A_UNIT0_BIT];
   wire i2c_port_gate = serial_clock_gate_q[`PCG_I2C_PORT_BIT];
   wire async_port1_gate = serial_clock_gate_q[`PCG_ASYNC_PORT1_BIT];
   wire async_port0_gate = serial_clock_gate_q[`PCG_ASYNC_PORT0_BIT];
   wire realtime_clock_gate = rtc_sio_clock_gate_q[`PCG_REALTIME_CLOCK_BIT];
   wire sync_serial_gate = rtc_sio_clock_gate_q[`PCG_SYNC_SERIAL_BIT];
   wire [5:0] ext_irq_gates = ext_irq_clock_gate_q[5:0];

   assign gates.enable[`PCG_G_TIMER+3] = timer_pair_b_gate;
   assign gates.enable[`PCG_G_TIMER+2] = timer_pair_a_gate;
   assign gates.enable[`PCG_G_TIMER+1] = timer_a_unit1_gate;
   assign gates.enable[`PCG_G_TIMER] = timer_a_unit0_gate;
   assign gates.enable[`PCG_G_SERIAL+2] = i2c_port_gate;
   assign gates.enable[`PCG_G_SERIAL+1] = async_port1_gate;
   assign gates.enable[`PCG_G_SERIAL] = async_port0_gate;
   assign gates.enable[`PCG_G_RTC] = realtime_clock_gate;
   assign gates.enable[`PCG_G_SIO] = sync_serial_gate;
   assign gates.enable[`PCG_G_EXT_IRQ+5:`PCG_G_EXT_IRQ] = ext_irq_gates;

   pcg_gate_bank u_gate_bank (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .gates(gates.bank)
   );

   assign gclk_q = gates.gclk;

   // ---------------- outputs ----------------
   assign avs_waitrequest = waitrequest_q;
   assign avs_readdata = readdata_q;
   assign avs_response = response_q;
   // gated clocks come straight from the gate bank flops
   assign timer_clk = gclk_q[`PCG_G_TIMER+3:`PCG_G_TIMER];
   assign serial_clk = gclk_q[`PCG_G_SERIAL+2:`PCG_G_SERIAL];
   assign rtc_clk = gclk_q[`PCG_G_RTC];
   assign sio_clk = gclk_q[`PCG_G_SIO];
   assign ext_irq_clk = gclk_q[`PCG_G_EXT_IRQ+5:`PCG_G_EXT_IRQ];
endmodule : pcg_top

// >>> test/pcg_sva.sv
// checker of the gating register bus and the gated basic clocks
// assumes it is bound onto pcg_top, registers at byte address 4*index
`timescale 1ns/100ps
module pcg_chk (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic [13:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic [1:0] avs_response,
   input wire logic [3:0] timer_clk,
   input wire logic [2:0] serial_clk,
   input wire logic rtc_clk,
   input wire logic sio_clk,
   input wire logic [5:0] ext_irq_clk
);
   wire req = avs_read || avs_write;
   wire acc = req && !avs_waitrequest;
   // only word-aligned gating and status addresses are mapped
   wire hit = (avs_address[13:4] == 10'h3dd && avs_address[1:0] == 2'b00)
      || avs_address == 14'h3de0;
   wire t0_wr = acc && avs_write && avs_byteenable[0]
      && avs_address == 14'h3dd0;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   a_wait_one: assert property (req && avs_waitrequest |=> !avs_waitrequest)
      else $error("request not accepted after one wait cycle");
   a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low for more than one cycle");
   a_ack_cause: assert property ($fell(avs_waitrequest) |-> $past(req))
      else $error("accept without a request");
   a_unmapped_err: assert property (
      acc && !hit && avs_address[1:0] == 2'b00 |-> avs_response == 2'b11
      && (avs_write || avs_readdata == 32'h0))
      else $error("unmapped access not refused");
   a_mapped_ok: assert property (acc && hit |-> avs_response == 2'b00)
      else $error("mapped access refused");
   a_reset_clear: assert property ($rose(rstn) |-> avs_readdata == 0
      && {ext_irq_clk, sio_clk, rtc_clk, serial_clk, timer_clk} == 0)
      else $error("outputs not clear after reset");
   a_gate_off: assert property (
      t0_wr && !avs_writedata[0] |=> ##1 !timer_clk[0] [*2])
      else $error("disabled clock still running");
   a_gate_on: assert property (
      t0_wr && avs_writedata[0] |=> ##1 $changed(timer_clk[0]) [*2])
      else $error("enabled clock not toggling");
   a_full_pulse: assert property (timer_clk[0] |=> !timer_clk[0])
      else $error("gated clock high pulse not one cycle");
   c_unmapped: cover property (acc && avs_response == 2'b11);
   c_timer_on: cover property (t0_wr && avs_writedata[0]);
   c_irq_run: cover property (ext_irq_clk[5]);
endmodule : pcg_chk

bind pcg_top pcg_chk i_chk (.sys_clk(sys_clk), .rstn(rstn),
   .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
   .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
   .avs_response(avs_response), .timer_clk(timer_clk),
   .serial_clk(serial_clk), .rtc_clk(rtc_clk), .sio_clk(sio_clk),
   .ext_irq_clk(ext_irq_clk));

// >>> test/pcg_periph_model.sv
// peripheral side: counts the basic clock edges each peripheral receives
// assumes the gate vector layout of pcg_regs.svh
`timescale 1ns/100ps
`include "pcg_regs.svh"
module pcg_periph_model (
   input wire logic rstn,
   input wire pcg_pkg::pcg_gate_vec_t gclk,
   output int edges [`PCG_NUM_GATES]
);
   for (genvar g = 0; g < `PCG_NUM_GATES; g++) begin : g_cnt
      always @(posedge gclk[g] or negedge rstn) begin
         if (!rstn)
            edges[g] <= 0;
         else
            edges[g] <= edges[g] + 1;
      end
   end
endmodule : pcg_periph_model

// >>> test/peripheral_clock_gating_tb_top.sv
// bench: sets gating registers over avalon, counts the gated clocks
// assumes pcg_top, its checker and the peripheral model; 5 ns sys_clk
`timescale 1ns/100ps
`include "pcg_regs.svh"
module peripheral_clock_gating_tb_top;
   logic sys_clk = 0, rstn = 0, avs_read = 0, avs_write = 0;
   logic [13:0] avs_address = '0;
   logic [31:0] avs_writedata = '0, avs_readdata, rd;
   logic [3:0] avs_byteenable = '0, timer_clk;
   logic avs_waitrequest, rtc_clk, sio_clk;
   logic [1:0] avs_response, rsp;
   logic [2:0] serial_clk;
   logic [5:0] ext_irq_clk;
   int edges [`PCG_NUM_GATES], snap [`PCG_NUM_GATES];
   int n_errors = 0, checked = 0;
   localparam int gbit [15] = '{0, 1, 4, 5, 0, 1, 4, 1, 0, 0, 1, 2, 3, 4, 5};
   localparam int greg [15] = '{0, 0, 0, 0, 1, 1, 1, 2, 2, 3, 3, 3, 3, 3, 3};
   always #2.5 sys_clk = ~sys_clk;
   pcg_top i_dut (.sys_clk(sys_clk), .rstn(rstn), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .avs_response(avs_response), .timer_clk(timer_clk),
      .serial_clk(serial_clk), .rtc_clk(rtc_clk), .sio_clk(sio_clk),
      .ext_irq_clk(ext_irq_clk));
   pcg_periph_model i_per (.rstn(rstn), .edges(edges),
      .gclk({ext_irq_clk, sio_clk, rtc_clk, serial_clk, timer_clk}));
   task automatic chk(input bit ok, input string m);
      checked++;
      if (!ok) begin
         n_errors++;
         $display("BAD %0t %s", $time, m);
      end
   endtask : chk
   // one access; the gap edge first keeps release and next drive apart
   task automatic bus(input bit wr, input logic [13:0] a, input logic [7:0] d,
      input logic [3:0] be);
      int n;
      @(posedge sys_clk);
      avs_read <= !wr;
      avs_write <= wr;
      avs_address <= a;
      avs_writedata <= {24'h0, d};
      avs_byteenable <= be;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      chk(n < 50, "bus hang");
      rd = avs_readdata;
      rsp = avs_response;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask : bus
   function automatic logic [13:0] ra(int r);
      return 14'h3dd0 + 14'(4 * r);
   endfunction : ra
   task automatic t_reset();
      for (int r = 0; r < 4; r++) begin
         bus(0, ra(r), 8'h00, 4'hf);
         chk(rd === 32'h0 && rsp === 2'b00, "reset value");
      end
   endtask : t_reset
   task automatic t_rw();
      for (int r = 0; r < 4; r++) begin
         bus(1, ra(r), 8'ha5, 4'hf);
         bus(1, ra(r), 8'h5a, 4'he);
         bus(0, ra(r), 8'h00, 4'hf);
         chk(rd === 32'ha5, "read back");
         bus(1, ra(r), 8'h00, 4'hf);
      end
   endtask : t_rw
   task automatic t_gates();
      bit quiet;
      for (int g = 0; g < 15; g++) begin
         bus(1, ra(greg[g]), 8'(1 << gbit[g]), 4'hf);
         repeat (3) @(posedge sys_clk);
         snap = edges;
         repeat (10) @(posedge sys_clk);
         quiet = 1;
         foreach (edges[k])
            if (k != g && edges[k] != snap[k])
               quiet = 0;
         chk(edges[g] - snap[g] == 5 && quiet, "gate on");
         bus(0, 14'h3de0, 8'h00, 4'hf);
         chk(rd === (32'h1 << g), "status while on");
         bus(1, ra(greg[g]), 8'h00, 4'hf);
         repeat (3) @(posedge sys_clk);
         snap = edges;
         repeat (10) @(posedge sys_clk);
         chk(edges == snap, "gate off");
         bus(0, 14'h3de0, 8'h00, 4'hf);
         chk(rd === 32'h0, "status while off");
      end
   endtask : t_gates
   // registers set, then a reset in mid-run must clear them again
   task automatic t_midreset();
      for (int r = 0; r < 4; r++)
         bus(1, ra(r), 8'hff, 4'hf);
      @(posedge sys_clk);
      rstn <= 1'b0;
      repeat (2) @(posedge sys_clk);
      rstn <= 1'b1;
      snap = edges;
      for (int r = 0; r < 4; r++) begin
         bus(0, ra(r), 8'h00, 4'hf);
         chk(rd === 32'h0 && rsp === 2'b00, "mid-run reset value");
      end
      repeat (4) @(posedge sys_clk);
      chk(edges == snap, "clock after reset");
   endtask : t_midreset
   // unmapped index just past status; the reserved region stays untouched
   task automatic t_unmapped();
      bus(1, 14'h3de4, 8'hff, 4'hf);
      chk(rsp === 2'b11, "unmapped write");
      bus(0, 14'h3de4, 8'h00, 4'hf);
      chk(rd === 32'h0 && rsp === 2'b11, "unmapped read");
   endtask : t_unmapped
   task automatic give_verdict();
      $display("errors %0d checks %0d", n_errors, checked);
      if (n_errors == 0 && checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : give_verdict
   initial begin
      repeat (2) @(posedge sys_clk);
      rstn <= 1'b1;
      t_reset();
      t_rw();
      t_unmapped();
      t_gates();
      t_midreset();
      give_verdict();
   end
   // the whole run needs about 670 cycles
   initial begin
      #50000;
      n_errors++;
      give_verdict();
   end
endmodule : peripheral_clock_gating_tb_top
